// ### port1_strap_map.vh
`ifndef PORT1_STRAP_MAP_VH
`define PORT1_STRAP_MAP_VH

// Register offsets on the local register port.
`define OFS_BASIC_CTRL 4'h0
`define OFS_ADVERT 4'h1
`define OFS_SPECIAL_MODE 4'h2
`define OFS_MANUAL_FC 4'h3
`define OFS_STRAP_STATUS 4'h4

// Field positions.
`define BIT_RATE_SELECT 13
`define BIT_FULL_DUPLEX 8
`define BIT_AUTONEG_EN 12
`define BIT_ADV_10_FULL 6
`define BIT_ADV_10_HALF 5
`define MODE_HI 2
`define MODE_LO 0
`define BIT_TX_PAUSE 2
`define BIT_RX_PAUSE 1
`define BIT_BACKPRESSURE 0
`define BIT_MANUAL_FC 3

// Strap defaults when the strap source is left at its idle level.
`define STRAP_SPEED_DEFAULT 1'h1
`define STRAP_DUPLEX_DEFAULT 1'h1
`define STRAP_BP_DEFAULT 1'h1
`define STRAP_PAUSE_DEFAULT 1'h1

// Mode field encodings.
`define MODE_10_HALF 3'h0
`define MODE_10_FULL 3'h1
`define MODE_100_HALF 3'h2
`define MODE_100_FULL 3'h3

// Values held while srst is high; they match the straps at their idle level.
`define RST_BASIC_CTRL 16'h3100
`define RST_ADVERT 16'h0000
`define RST_MODE 3'h3
`define RST_MANUAL_FC 4'h7
`define STRAP_IDLE 4'hf

// Strap positions in the synchronised word and in the strap status register.
`define STRAP_POS_SPEED 3
`define STRAP_POS_DUPLEX 2
`define STRAP_POS_BP 1
`define STRAP_POS_PAUSE 0

// Last settle count before the straps are taken; the synchroniser needs two edges to fill.
`define SETTLE_LAST 2'h2

`endif

// ### strap_sync.v
`timescale 1ns/1ps
`include "port1_strap_map.vh"
// Two-flop synchroniser for the four strap levels.
module strap_sync (
    input wire sys_clk,
    input wire srst,
    input wire [3:0] async_in,
    output reg [3:0] sync_out
);
    reg [3:0] stage1;

    always @(posedge sys_clk) begin
        if (srst) begin
            stage1 <= `STRAP_IDLE;
            sync_out <= `STRAP_IDLE;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // strap_sync

// ### port1_strap_defaults.v
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Speed strap sets the rate select low bit default; high means 100 Mbps.
// - Speed strap sets defaults of 10BASE-T full and half advertisement bits 6, 5.
// - Speed and duplex straps together set the 3-bit special mode default.
// - Duplex strap sets the full duplex select default; high means full duplex.
// - Duplex strap also sets the default of 10BASE-T full advertisement bit 6.
// - Backpressure strap sets the backpressure enable default; high enables it.
// - Pause strap sets tx and rx pause defaults, used under manual flow control.
// - Low pause strap disables pause detection and generation; default is high.
`include "port1_strap_map.vh"

module port1_strap_defaults (
    input wire sys_clk,
    input wire srst,
    input wire port1_speed_default_input,
    input wire port1_duplex_default_input,
    input wire port1_backpressure_default_input,
    input wire port1_pause_default_input,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output wire rate_select_low_bit,
    output wire full_duplex_select,
    output wire adv_10_full,
    output wire adv_10_half,
    output wire [2:0] special_mode,
    output wire port1_backpressure_enable,
    output wire port1_tx_pause_enable,
    output wire port1_rx_pause_enable,
    output wire port1_manual_flow_ctrl,
    output wire tx_pause_active,
    output wire rx_pause_active,
    output wire load_done
);
    // One-hot sequencer: let the synchroniser fill, take the straps once, then run.
    localparam [2:0] ST_SETTLE = 3'b001;
    localparam [2:0] ST_LOAD = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;

    // Straps rest high, so the chain resets to that level and an open pin gives the defaults.
    wire [3:0] strap_sync_level;

    strap_sync u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in({port1_speed_default_input, port1_duplex_default_input,
                   port1_backpressure_default_input, port1_pause_default_input}),
        .sync_out(strap_sync_level)
    );

    wire s_speed = strap_sync_level[`STRAP_POS_SPEED];
    wire s_duplex = strap_sync_level[`STRAP_POS_DUPLEX];
    wire s_bp = strap_sync_level[`STRAP_POS_BP];
    wire s_pause = strap_sync_level[`STRAP_POS_PAUSE];

    reg [2:0] state;
    reg [2:0] next_state;
    reg [1:0] settle;
    reg [1:0] next_settle;
    reg loaded;
    reg next_loaded;

    // Loading waits for the synchroniser to fill with the real pin levels after release.
    wire do_load = (state == ST_LOAD);
    // An early write to a field the load sets would be lost to it, so every write is refused until the load is in.
    wire wr_ok = reg_wr && loaded;

    function [2:0] mode_of;
        input spd;
        input dup;
        begin
            case ({spd, dup})
                2'b00: mode_of = `MODE_10_HALF;
                2'b01: mode_of = `MODE_10_FULL;
                2'b10: mode_of = `MODE_100_HALF;
                default: mode_of = `MODE_100_FULL;
            endcase
        end
    endfunction

    // The 10BASE-T abilities are offered only when the speed strap picks 10 Mbps, so a
    // partner cannot settle on a rate other than the strapped one.
    function adv_full_of;
        input spd;
        input dup;
        begin
            adv_full_of = !spd && dup;
        end
    endfunction

    function adv_half_of;
        input spd;
        begin
            adv_half_of = !spd;
        end
    endfunction

    function is_at;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            is_at = (addr == ofs);
        end
    endfunction

    reg [15:0] basic_ctrl;
    reg [15:0] next_basic_ctrl;
    reg [15:0] advert;
    reg [15:0] next_advert;
    reg [2:0] mode_field;
    reg [2:0] next_mode_field;
    reg [3:0] manual_fc;
    reg [3:0] next_manual_fc;
    reg [3:0] strap_seen;
    reg [3:0] next_strap_seen;
    reg [15:0] next_rdata;

    always @* begin
        next_state = state;
        next_settle = settle;
        next_loaded = loaded;
        case (state)
            ST_SETTLE: begin
                next_settle = settle + 2'h1;
                if (settle == `SETTLE_LAST)
                    next_state = ST_LOAD;
            end
            ST_LOAD: begin
                next_loaded = 1'b1;
                next_state = ST_RUN;
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_SETTLE;
                next_settle = 2'h0;
            end
        endcase
    end

    always @* begin
        next_basic_ctrl = basic_ctrl;
        next_advert = advert;
        next_mode_field = mode_field;
        next_manual_fc = manual_fc;
        next_strap_seen = strap_seen;
        if (do_load) begin
            next_strap_seen = strap_sync_level;
            next_basic_ctrl[`BIT_RATE_SELECT] = s_speed;
            next_basic_ctrl[`BIT_FULL_DUPLEX] = s_duplex;
            next_advert[`BIT_ADV_10_FULL] = adv_full_of(s_speed, s_duplex);
            next_advert[`BIT_ADV_10_HALF] = adv_half_of(s_speed);
            next_mode_field = mode_of(s_speed, s_duplex);
            next_manual_fc[`BIT_BACKPRESSURE] = s_bp;
            next_manual_fc[`BIT_TX_PAUSE] = s_pause;
            next_manual_fc[`BIT_RX_PAUSE] = s_pause;
        end else if (wr_ok) begin
            // Writes after the load override the strap values until the next reset.
            if (is_at(reg_addr, `OFS_BASIC_CTRL))
                next_basic_ctrl = reg_wdata;
            if (is_at(reg_addr, `OFS_ADVERT))
                next_advert = reg_wdata;
            if (is_at(reg_addr, `OFS_SPECIAL_MODE))
                next_mode_field = reg_wdata[`MODE_HI:`MODE_LO];
            if (is_at(reg_addr, `OFS_MANUAL_FC))
                next_manual_fc = reg_wdata[3:0];
        end
    end

    // Read data stands for one cycle only; an idle bus reads as zero.
    always @* begin
        next_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_BASIC_CTRL: next_rdata = basic_ctrl;
                `OFS_ADVERT: next_rdata = advert;
                `OFS_SPECIAL_MODE: next_rdata = {13'h0000, mode_field};
                `OFS_MANUAL_FC: next_rdata = {12'h000, manual_fc};
                `OFS_STRAP_STATUS: next_rdata = {11'h000, loaded, strap_seen};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            state <= ST_SETTLE;
            settle <= 2'h0;
            loaded <= 1'b0;
            basic_ctrl <= `RST_BASIC_CTRL;
            advert <= `RST_ADVERT;
            mode_field <= `RST_MODE;
            manual_fc <= `RST_MANUAL_FC;
            strap_seen <= `STRAP_IDLE;
            reg_rdata <= 16'h0000;
        end else begin
            state <= next_state;
            settle <= next_settle;
            loaded <= next_loaded;
            basic_ctrl <= next_basic_ctrl;
            advert <= next_advert;
            mode_field <= next_mode_field;
            manual_fc <= next_manual_fc;
            strap_seen <= next_strap_seen;
            reg_rdata <= next_rdata;
        end
    end

    assign rate_select_low_bit = basic_ctrl[`BIT_RATE_SELECT];
    assign full_duplex_select = basic_ctrl[`BIT_FULL_DUPLEX];
    assign adv_10_full = advert[`BIT_ADV_10_FULL];
    assign adv_10_half = advert[`BIT_ADV_10_HALF];
    assign special_mode = mode_field;
    assign port1_backpressure_enable = manual_fc[`BIT_BACKPRESSURE];
    assign port1_tx_pause_enable = manual_fc[`BIT_TX_PAUSE];
    assign port1_rx_pause_enable = manual_fc[`BIT_RX_PAUSE];
    assign port1_manual_flow_ctrl = manual_fc[`BIT_MANUAL_FC];
    // Pause enables only act under manual flow control.
    assign tx_pause_active = port1_manual_flow_ctrl & port1_tx_pause_enable;
    assign rx_pause_active = port1_manual_flow_ctrl & port1_rx_pause_enable;
    assign load_done = loaded;
endmodule // port1_strap_defaults

// ### strap_source.sv
`timescale 1ns/1ps
module strap_source (
    input wire drive_en,
    input wire [3:0] level,
    output wire [3:0] straps
);
    // Undriven straps rest at their pulled-up level, so the high defaults apply.
    assign straps = drive_en ? level : 4'hf;
endmodule // strap_source

// ### strap_defaults_checker.sv
`timescale 1ns/1ps
module strap_defaults_checker (
    input wire sys_clk,
    input wire srst,
    input wire port1_speed_default_input,
    input wire port1_duplex_default_input,
    input wire port1_backpressure_default_input,
    input wire port1_pause_default_input,
    input wire rate_select_low_bit,
    input wire full_duplex_select,
    input wire adv_10_full,
    input wire adv_10_half,
    input wire [2:0] special_mode,
    input wire port1_backpressure_enable,
    input wire port1_tx_pause_enable,
    input wire port1_rx_pause_enable,
    input wire port1_manual_flow_ctrl,
    input wire tx_pause_active,
    input wire rx_pause_active,
    input wire load_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence loaded;
        $rose(load_done);
    endsequence
    rate_map_a: assert property (loaded |-> rate_select_low_bit == port1_speed_default_input)
        else $error("bad rate");
    dup_map_a: assert property (loaded |-> full_duplex_select == port1_duplex_default_input)
        else $error("bad duplex");
    adv_map_a: assert property (loaded |->
        adv_10_full == (!port1_speed_default_input && port1_duplex_default_input)
        && adv_10_half == !port1_speed_default_input) else $error("bad advert");
    mode_map_a: assert property (loaded |->
        special_mode == {1'b0, port1_speed_default_input, port1_duplex_default_input})
        else $error("bad mode");
    bp_map_a: assert property (loaded |-> port1_backpressure_enable == port1_backpressure_default_input)
        else $error("bad bp");
    pause_map_a: assert property (loaded |->
        port1_tx_pause_enable == port1_pause_default_input
        && port1_rx_pause_enable == port1_pause_default_input) else $error("bad pause");
    pause_gate_a: assert property (load_done |->
        tx_pause_active == (port1_manual_flow_ctrl && port1_tx_pause_enable))
        else $error("bad gate");
    rx_gate_a: assert property (load_done |->
        rx_pause_active == (port1_manual_flow_ctrl && port1_rx_pause_enable))
        else $error("bad rx gate");
    load_once_a: assert property (load_done |=> load_done) else $error("reload");
endmodule // strap_defaults_checker
bind port1_strap_defaults strap_defaults_checker u_chk (.*);

// ### port1_strap_defaults_tb.sv
`timescale 1ns/1ps
module port1_strap_defaults_tb;
    logic sys_clk = 0, srst = 1, wr = 0, rd = 0, en = 0;
    logic [3:0] addr = 0, lv = 0;
    logic [15:0] wd = 0;
    wire [15:0] rdata;
    wire [3:0] st;
    wire ld;
    wire txa;
    wire rxa;
    int checks = 0, mismatches = 0;
    // Each row is {expected mode, speed, duplex, backpressure, pause}.
    logic [6:0] rows [4] = '{7'h00, 7'h3f, 7'h2a, 7'h15};
    always #4 sys_clk = ~sys_clk;
    strap_source u_src (.drive_en(en), .level(lv), .straps(st));
    port1_strap_defaults u_dut (.sys_clk(sys_clk), .srst(srst), .port1_speed_default_input(st[3]),
        .port1_duplex_default_input(st[2]), .port1_backpressure_default_input(st[1]),
        .port1_pause_default_input(st[0]), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .rate_select_low_bit(), .full_duplex_select(),
        .adv_10_full(), .adv_10_half(), .special_mode(), .port1_backpressure_enable(),
        .port1_tx_pause_enable(), .port1_rx_pause_enable(), .port1_manual_flow_ctrl(),
        .tx_pause_active(txa), .rx_pause_active(rxa), .load_done(ld));
    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input [15:0] e, input [15:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task rdc(input [3:0] a, input [15:0] e);
        @(posedge sys_clk) addr <= a;
        rd <= 1;
        @(posedge sys_clk) rd <= 0;
        #1 chk("rdata", e, rdata);
    endtask
    task wr1(input [3:0] a, input [15:0] v);
        @(posedge sys_clk) addr <= a;
        wd <= v;
        wr <= 1;
        @(posedge sys_clk) wr <= 0;
    endtask
    task boot(input [3:0] l, input e, input early);
        @(posedge sys_clk) lv <= l;
        en <= e;
        srst <= 1;
        repeat (20) @(posedge sys_clk);
        chk("load_in_reset", 16'h0000, {15'h0000, ld});
        srst <= 0;
        // A write while the straps settle must be refused.
        if (early) wr1(3, 16'h0008);
        for (int i = 0; i < 20 && ld !== 1'b1; i++) @(posedge sys_clk);
        if (ld !== 1'b1) begin
            mismatches++;
            stop_test();
        end
    endtask
    initial begin
        foreach (rows[i]) begin
            boot(rows[i][3:0], 1, 0);
            rdc(0, {2'b0, rows[i][3], 4'h8, rows[i][2], 8'h00});
            rdc(1, {9'h000, ~rows[i][3] & rows[i][2], ~rows[i][3], 5'h00});
            rdc(2, {13'h0000, rows[i][6:4]});
            rdc(3, {13'h0000, rows[i][0], rows[i][0], rows[i][1]});
        end
        boot(4'h0, 0, 1);
        rdc(3, 16'h0007);
        rdc(0, 16'h3100);
        chk("pause_active", 16'h0000, {14'h0000, txa, rxa});
        wr1(3, 16'h0008);
        rdc(3, 16'h0008);
        chk("pause_active", 16'h0000, {14'h0000, txa, rxa});
        wr1(3, 16'h000f);
        rdc(3, 16'h000f);
        chk("pause_active", 16'h0003, {14'h0000, txa, rxa});
        rdc(5, 16'h0000);
        wr1(4, 16'h0000);
        rdc(4, 16'h001f);
        @(posedge sys_clk) #1 chk("rdata_idle", 16'h0000, rdata);
        stop_test();
    end
endmodule // port1_strap_defaults_tb
